// ---- src/eeprom_pkg.sv ----
// Shared constants and types for the three-wire serial EEPROM command logic
package eeprom_pkg;

    localparam int          ARRAY_BYTES      = 2048;
    localparam int          BYTE_ADDR_BITS   = 11;
    localparam int          WORD_ADDR_BITS   = 10;
    localparam int          BYTE_DATA_BITS   = 8;
    localparam int          WORD_DATA_BITS   = 16;
    localparam logic [1:0]  OPC_EXT          = 2'h0;
    localparam logic [1:0]  OPC_WRITE        = 2'h1;
    localparam logic [1:0]  OPC_READ         = 2'h2;
    localparam logic [1:0]  OPC_ERASE        = 2'h3;
    localparam logic [1:0]  EXT_DISABLE      = 2'h0;
    localparam logic [1:0]  EXT_WRITE_ALL    = 2'h1;
    localparam logic [1:0]  EXT_ERASE_ALL    = 2'h2;
    localparam logic [1:0]  EXT_ENABLE       = 2'h3;
    localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
    localparam int          CLK_SYS_MHZ      = 250;
    localparam int          PROGRAM_TIME_US  = 2000;
    localparam int          PROGRAM_CYCLES   = PROGRAM_TIME_US * CLK_SYS_MHZ;
    localparam int          CS_LOW_NS        = 250;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_OPC   = 3'h1,
        ST_ADDR  = 3'h3,
        ST_DATA  = 3'h2,
        ST_READ  = 3'h6,
        ST_DONE  = 3'h7
    } link_state_e;

    // Program request carried from the link domain to the system domain
    typedef struct packed {
        logic        all;
        logic        erase;
        logic [10:0] addr;
        logic [15:0] data;
        logic        wide;
    } prog_req_s;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_out_s;

endpackage : eeprom_pkg

// ---- src/three_wire_eeprom_command_logic.sv ----
// Command logic, array and self-timed programming of the serial EEPROM
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Power-up leaves programming disabled; erase and write rejected until enable.
// - Enable persists until the disable instruction or power removal.
// - Read works whatever the enable latch holds.
// - Read sends one zero bit then 8 or 16 data bits.
// - Read output bits change on rising serial clock.
// - Chip select held high keeps reading the next addresses.
// - Write takes 8 or 16 data bits; programming starts on last bit.
// - After chip select low then high, output shows busy low, ready high.
// - Start bit then chip select low stops status on the output.
// - Write-all erases then programs every location; needs programming enabled.
// - Programming finishes without further serial clocks.
// - Chip select low gives standby, after any running programming cycle.
// - Chip select low holds the command state machine in reset.
// - Inputs sampled and outputs shifted on rising serial clock.
// - Serial clock may stop at either level without losing state.
// - Clocks ignored with chip select low or before a start bit.
// - Full clock count needed; afterwards clocks ignored until chip select low, except a read keeps shifting.
// - Chip select low through a cycle keeps output off; later status high.
// - Organization pin high selects 16-bit words, low selects bytes.
// - Program permit pin low blocks all programming.
// - Start bit is first rising edge with chip select and data high.
// - Opcodes 10 read, 01 write, 11 erase, 00 extended by address.
// - Word erase sets every bit of the location to one.
// - Output released on the falling edge of chip select.
module three_wire_eeprom_command_logic #(
    parameter int PROGRAM_CYCLES_P = eeprom_pkg::PROGRAM_CYCLES,
    parameter bit HAS_ORG_PIN      = 1'b1,
    parameter bit FIXED_WIDE       = 1'b0,
    parameter bit HAS_PERMIT_PIN   = 1'b1
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 serial_clk,
    input  wire logic                 chip_select,
    input  wire logic                 serial_in,
    input  wire logic                 word_size_select_pin,
    input  wire logic                 program_permit_pin,
    output eeprom_pkg::pin_out_s      serial_out,
    output logic                      busy
);
    import eeprom_pkg::*;

    if (PROGRAM_CYCLES_P < 1) begin : g_bad_cycles
        $error("PROGRAM_CYCLES_P out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // Array, written only from the system domain
    logic [7:0] mem_reg [ARRAY_BYTES];

    function automatic logic [10:0] byte_index(input logic [10:0] a, input logic wide,
                                               input logic hi);
        byte_index = wide ? {a[9:0], hi} : a;
    endfunction : byte_index

    //////////////////////////////////////////////////////////////////////////
    // System domain: synchronise pins and link handshake
    logic       req_toggle_reg;
    logic       busy_seen_reg;
    logic [1:0] req_sync_reg;
    logic       req_seen_reg;
    logic [1:0] org_sync_reg;
    logic [1:0] pe_sync_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req_sync_reg <= 2'h0;
            req_seen_reg <= 1'b0;
            org_sync_reg <= 2'h0;
            pe_sync_reg  <= 2'h0;
        end else begin
            req_sync_reg <= {req_sync_reg[0], req_toggle_reg};
            req_seen_reg <= req_sync_reg[1];
            org_sync_reg <= {org_sync_reg[0], word_size_select_pin};
            pe_sync_reg  <= {pe_sync_reg[0], program_permit_pin};
        end
    end

    logic wide_sys;
    logic permit_sys;
    assign wide_sys   = HAS_ORG_PIN ? org_sync_reg[1] : FIXED_WIDE;
    assign permit_sys = HAS_PERMIT_PIN ? pe_sync_reg[1] : 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // Link domain: serial command state machine, reset while deselected
    link_state_e state_reg;
    link_state_e state_next;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [1:0]  opc_reg;
    logic [1:0]  opc_next;
    logic [10:0] addr_reg;
    logic [10:0] addr_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic        wide_reg;
    logic        wide_next;
    logic        enable_reg;
    logic        enable_next;
    logic        toggle_next;
    prog_req_s   req_reg;
    prog_req_s   req_next;
    logic        dout_reg;
    logic        dout_next;
    logic        status_reg;
    logic        status_next;
    logic [1:0]  lnk_wide_sync_reg;
    logic [1:0]  lnk_busy_sync_reg;

    function automatic logic [4:0] addr_len(input logic wide);
        addr_len = wide ? 5'(WORD_ADDR_BITS) : 5'(BYTE_ADDR_BITS);
    endfunction : addr_len

    function automatic logic [4:0] data_len(input logic wide);
        data_len = wide ? 5'(WORD_DATA_BITS) : 5'(BYTE_DATA_BITS);
    endfunction : data_len

    function automatic logic [15:0] read_word(input logic [10:0] a, input logic wide);
        read_word = wide ? {mem_reg[byte_index(a, 1'b1, 1'b1)],
                            mem_reg[byte_index(a, 1'b1, 1'b0)]}
                         : {mem_reg[a], 8'h00};
    endfunction : read_word

    // Enable latch lives on the link clock but survives deselect
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_reg        <= 1'b0;
            req_toggle_reg    <= 1'b0;
            req_reg           <= '0;
            lnk_wide_sync_reg <= 2'h0;
            lnk_busy_sync_reg <= 2'h0;
        end else begin
            enable_reg        <= enable_next;
            req_toggle_reg    <= toggle_next;
            req_reg           <= req_next;
            lnk_wide_sync_reg <= {lnk_wide_sync_reg[0], wide_sys};
            lnk_busy_sync_reg <= {lnk_busy_sync_reg[0], busy};
        end
    end

    // Chip select low is an asynchronous reset of the sequencer
    always_ff @(posedge serial_clk or negedge chip_select) begin
        if (!chip_select) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 5'h0;
            opc_reg    <= 2'h0;
            addr_reg   <= 11'h000;
            shift_reg  <= 16'h0000;
            wide_reg   <= 1'b0;
            dout_reg   <= 1'b0;
            status_reg <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            opc_reg    <= opc_next;
            addr_reg   <= addr_next;
            shift_reg  <= shift_next;
            wide_reg   <= wide_next;
            dout_reg   <= dout_next;
            status_reg <= status_next;
        end
    end

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        opc_next    = opc_reg;
        addr_next   = addr_reg;
        shift_next  = shift_reg;
        wide_next   = wide_reg;
        dout_next   = dout_reg;
        status_next = status_reg;
        enable_next = enable_reg;
        toggle_next = req_toggle_reg;
        req_next    = req_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (serial_in) begin
                    state_next  = ST_OPC;
                    status_next = 1'b0;
                    cnt_next    = 5'h0;
                    wide_next   = lnk_wide_sync_reg[1];
                end
            end
            ST_OPC: begin
                opc_next = {opc_reg[0], serial_in};
                if (cnt_reg == 5'h1) begin
                    state_next = ST_ADDR;
                    cnt_next   = 5'h0;
                end else begin
                    cnt_next = cnt_reg + 5'h1;
                end
            end
            ST_ADDR: begin
                addr_next = {addr_reg[9:0], serial_in};
                cnt_next  = cnt_reg + 5'h1;
                if (cnt_reg == addr_len(wide_reg) - 5'h1) begin
                    cnt_next = 5'h0;
                    unique case (opc_reg)
                        OPC_READ: begin
                            state_next = ST_READ;
                            dout_next  = 1'b0;
                            shift_next = read_word(addr_next, wide_reg);
                        end
                        OPC_ERASE: begin
                            state_next = ST_DONE;
                            if (enable_reg) begin
                                req_next    = '{all: 1'b0, erase: 1'b1, addr: addr_next,
                                                data: 16'hFFFF, wide: wide_reg};
                                toggle_next = ~req_toggle_reg;
                            end
                        end
                        OPC_WRITE: state_next = ST_DATA;
                        default: begin
                            state_next = ST_DONE;
                            unique case (addr_next[addr_len(wide_reg) - 5'h1 -: 2])
                                EXT_ENABLE:    enable_next = 1'b1;
                                EXT_DISABLE:   enable_next = 1'b0;
                                EXT_WRITE_ALL: state_next  = ST_DATA;
                                default: begin
                                    if (enable_reg) begin
                                        req_next    = '{all: 1'b1, erase: 1'b1,
                                                        addr: 11'h000, data: 16'hFFFF,
                                                        wide: wide_reg};
                                        toggle_next = ~req_toggle_reg;
                                    end
                                end
                            endcase
                        end
                    endcase
                end
            end
            ST_DATA: begin
                shift_next = {shift_reg[14:0], serial_in};
                cnt_next   = cnt_reg + 5'h1;
                if (cnt_reg == data_len(wide_reg) - 5'h1) begin
                    state_next = ST_DONE;
                    if (enable_reg) begin
                        req_next    = '{all: (opc_reg == OPC_EXT), erase: 1'b0,
                                        addr: addr_reg,
                                        data: wide_reg ? shift_next
                                                       : {8'h00, shift_next[7:0]},
                                        wide: wide_reg};
                        toggle_next = ~req_toggle_reg;
                    end
                end
            end
            ST_READ: begin
                dout_next  = shift_reg[15];
                shift_next = {shift_reg[14:0], 1'b0};
                cnt_next   = cnt_reg + 5'h1;
                if (cnt_reg == data_len(wide_reg) - 5'h1) begin
                    cnt_next   = 5'h0;
                    addr_next  = wide_reg ? {1'b0, addr_reg[9:0] + 10'h001}
                                          : addr_reg + 11'h001;
                    shift_next = read_word(addr_next, wide_reg);
                end
            end
            ST_DONE: state_next = ST_DONE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Output enable drops combinationally with chip select
    logic status_en;
    assign status_en = (state_reg == ST_IDLE) && status_reg
                       && (busy_seen_reg || lnk_busy_sync_reg[1]);
    assign serial_out.oe  = chip_select && ((state_reg == ST_READ) || status_en);
    assign serial_out.out = (state_reg == ST_READ) ? dout_reg : ~busy;

    //////////////////////////////////////////////////////////////////////////
    // System domain: self-timed programming engine
    logic        busy_next;
    logic [31:0] timer_reg;
    logic [31:0] timer_next;
    logic        busy_seen_next;
    logic [2:0]  frame_sync_reg;
    logic        start_prog;
    assign start_prog = (req_sync_reg[1] != req_seen_reg) && permit_sys;

    always_comb begin
        busy_next      = busy;
        timer_next     = timer_reg;
        busy_seen_next = busy_seen_reg;
        if (start_prog && !busy) begin
            busy_next      = 1'b1;
            timer_next     = 32'(PROGRAM_CYCLES_P);
            busy_seen_next = 1'b1;
        end else if (busy) begin
            timer_next = timer_reg - 32'h1;
            if (timer_reg == 32'h1) begin
                busy_next = 1'b0;
            end
        end
        // Start bit of a new frame withdraws status; a new cycle arms it again
        if (frame_sync_reg[2] && !frame_sync_reg[1] && !start_prog) begin
            busy_seen_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy          <= 1'b0;
            timer_reg     <= 32'h0;
            busy_seen_reg <= 1'b0;
            frame_sync_reg <= 3'h7;
        end else begin
            busy          <= busy_next;
            timer_reg     <= timer_next;
            busy_seen_reg <= busy_seen_next;
            frame_sync_reg <= {frame_sync_reg[1:0], status_reg};
        end
    end

    // Array update lands once, at the end of the timed cycle
    always_ff @(posedge clk_sys) begin
        if (busy && timer_reg == 32'h1) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                if (req_reg.all) begin
                    mem_reg[i] <= req_reg.wide ? (i[0] ? req_reg.data[15:8]
                                                       : req_reg.data[7:0])
                                               : req_reg.data[7:0];
                end else if (11'(i) == byte_index(req_reg.addr, req_reg.wide, 1'b0)
                             || (req_reg.wide
                                 && 11'(i) == byte_index(req_reg.addr, 1'b1, 1'b1))) begin
                    mem_reg[i] <= req_reg.erase ? ERASED_BYTE
                                : (i[0] && req_reg.wide) ? req_reg.data[15:8]
                                : req_reg.data[7:0];
                end
            end
        end
    end

endmodule : three_wire_eeprom_command_logic

// ---- test/three_wire_eeprom_command_logic_asserts.sv ----
// Checker for the serial EEPROM command logic ports
`timescale 1ns/1ps
module three_wire_eeprom_command_logic_asserts #(
    parameter int PROGRAM_CYCLES_P = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    input wire logic                 serial_clk,
    input wire logic                 chip_select,
    input wire logic                 serial_in,
    input wire logic                 word_size_select_pin,
    input wire logic                 program_permit_pin,
    input wire eeprom_pkg::pin_out_s serial_out,
    input wire logic                 busy
);
    import eeprom_pkg::*;
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    logic        started_reg;
    logic        started_next;

    //////////////////////////////////////////////////////////////////////////
    // Helper counters
    always_comb begin
        busy_cnt_next = busy ? busy_cnt_reg + 32'h1 : 32'h0;
        started_next  = started_reg | serial_in;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) busy_cnt_reg <= 32'h0;
        else busy_cnt_reg <= busy_cnt_next;
    end
    // Marks that the start bit of the current frame has been seen
    always_ff @(posedge serial_clk or negedge chip_select) begin
        if (!chip_select) started_reg <= 1'b0;
        else started_reg <= started_next;
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequences and properties
    sequence s_read_byte_hdr;
        chip_select && serial_in && !started_reg && !word_size_select_pin
            ##1 chip_select && serial_in ##1 chip_select && !serial_in
            ##1 chip_select[*8] ##1 chip_select[*3];
    endsequence
    sequence s_idle;
        (!busy)[*8];
    endsequence
    property p_oe_cs;
        @(posedge clk_sys) disable iff (!reset_n) !chip_select |-> !serial_out.oe;
    endproperty
    property p_busy_len;
        @(posedge clk_sys) disable iff (!reset_n)
            $fell(busy) |-> busy_cnt_reg == PROGRAM_CYCLES_P;
    endproperty
    property p_busy_hold;
        @(posedge clk_sys) disable iff (!reset_n) $rose(busy) |-> busy[*8];
    endproperty
    property p_permit;
        @(posedge clk_sys) disable iff (!reset_n) (!program_permit_pin)[*8] |=> !$rose(busy);
    endproperty
    property p_busy_out;
        @(posedge clk_sys) disable iff (!reset_n) busy && serial_out.oe |-> !serial_out.out;
    endproperty
    property p_reset_quiet;
        @(posedge clk_sys) disable iff (!reset_n) $rose(reset_n) |-> (!busy)[*8];
    endproperty
    property p_ready_high;
        @(posedge clk_sys) disable iff (!reset_n)
            s_idle ##1 ($rose(chip_select) && serial_out.oe) |-> serial_out.out;
    endproperty
    property p_dummy_zero;
        @(posedge serial_clk) disable iff (!reset_n)
            s_read_byte_hdr |=> !chip_select || (serial_out.oe && !serial_out.out);
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_busy_hold: assert property (p_busy_hold) else $error("busy pulse too short");
    a_permit: assert property (p_permit) else $error("busy with permit low");
    a_busy_out: assert property (p_busy_out) else $error("status high while busy");
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
    a_ready_high: assert property (p_ready_high) else $error("status low when idle");
    a_dummy_zero: assert property (p_dummy_zero) else $error("no dummy zero");
endmodule : three_wire_eeprom_command_logic_asserts

bind three_wire_eeprom_command_logic three_wire_eeprom_command_logic_asserts #(
    .PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)
) u_three_wire_eeprom_command_logic_asserts (
    .clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(serial_clk),
    .chip_select(chip_select), .serial_in(serial_in),
    .word_size_select_pin(word_size_select_pin), .program_permit_pin(program_permit_pin),
    .serial_out(serial_out), .busy(busy)
);

// ---- test/host_model.sv ----
// Host model that drives the three-wire serial bus
`timescale 1ns/1ps
module host_model (
    output logic                      serial_clk,
    output logic                      chip_select,
    output logic                      serial_in,
    input  wire eeprom_pkg::pin_out_s serial_out
);
    import eeprom_pkg::*;
    initial begin
        serial_clk  = 1'b0;
        chip_select = 1'b0;
        serial_in   = 1'b0;
    end
    task automatic open_frame;
        chip_select = 1'b1;
        #20;
    endtask : open_frame
    task automatic close_frame;
        chip_select = 1'b0;
        #260;
    endtask : close_frame
    // MSB first, each bit held across its rising edge
    task automatic tx(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            #32 serial_clk = 1'b1;
            #32 serial_clk = 1'b0;
        end
        serial_in = 1'b0;
    endtask : tx
    task automatic rx(input int n, output logic [31:0] v);
        v = 32'h0;
        for (int i = 0; i < n; i++) begin
            #32 serial_clk = 1'b1;
            #32 serial_clk = 1'b0;
            v = {v[30:0], serial_out.oe ? serial_out.out : 1'bx};
        end
    endtask : rx
    function automatic logic [1:0] status();
        return {serial_out.oe, serial_out.out};
    endfunction : status
endmodule : host_model

// ---- test/tb_three_wire_eeprom_command_logic.sv ----
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
module tb_three_wire_eeprom_command_logic;
    import eeprom_pkg::*;
    logic        clk_sys, reset_n, serial_clk, chip_select, serial_in, busy;
    logic        word_size_select_pin, program_permit_pin;
    pin_out_s    serial_out;
    int          miscompares, samples_checked, cycles;
    logic [31:0] got;

    three_wire_eeprom_command_logic #(.PROGRAM_CYCLES_P(200)) u_three_wire_eeprom_command_logic (
        .clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(serial_clk),
        .chip_select(chip_select), .serial_in(serial_in),
        .word_size_select_pin(word_size_select_pin), .program_permit_pin(program_permit_pin),
        .serial_out(serial_out), .busy(busy)
    );
    host_model u_host_model (
        .serial_clk(serial_clk), .chip_select(chip_select),
        .serial_in(serial_in), .serial_out(serial_out)
    );

    //////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic pins(input logic w, input logic p);
        @(posedge clk_sys);
        word_size_select_pin <= w;
        program_permit_pin   <= p;
        repeat (2) @(posedge clk_sys);
        #1;
        // Idle link clocks carry the new organization into the link domain
        u_host_model.tx(32'h0, 2);
    endtask : pins
    task automatic op(input logic [1:0] c, input logic [10:0] a);
        u_host_model.open_frame();
        if (word_size_select_pin) u_host_model.tx(32'({1'b1, c, a[9:0]}), 13);
        else u_host_model.tx(32'({1'b1, c, a}), 14);
    endtask : op
    task automatic ext(input logic [1:0] c);
        op(OPC_EXT, word_size_select_pin ? {1'b0, c, 8'h00} : {c, 9'h000});
    endtask : ext
    // Closes the frame, then watches the self-timed cycle without serial clocks
    task automatic done(input logic exp_busy);
        logic seen;
        u_host_model.close_frame();
        seen = 1'b0;
        repeat (60) @(posedge clk_sys) seen |= (busy === 1'b1);
        chk(32'(seen), 32'(exp_busy));
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_sys);
        chk(32'(busy), 32'h0);
    endtask : done
    task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic exp_busy);
        op(OPC_WRITE, a);
        if (word_size_select_pin) u_host_model.tx(32'(d), 16);
        else u_host_model.tx(32'(d[7:0]), 8);
        done(exp_busy);
    endtask : wr
    task automatic rd(input logic [10:0] a, input int n, input logic [31:0] e);
        op(OPC_READ, a);
        chk(32'(u_host_model.status()), 32'h2);
        u_host_model.rx(n, got);
        chk(got, e);
        u_host_model.close_frame();
    endtask : rd

    //////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_guard;
        pins(1'b0, 1'b1);
        wr(11'h005, 16'h003C, 1'b0);
        $display("test guard done");
    endtask : t_guard
    task automatic t_rw;
        ext(EXT_ENABLE);
        u_host_model.close_frame();
        wr(11'h006, 16'h005A, 1'b1);
        wr(11'h007, 16'h00C3, 1'b1);
        u_host_model.open_frame();
        chk(32'(u_host_model.status()), 32'h3);
        u_host_model.close_frame();
        rd(11'h006, 16, 32'h5AC3);
        ext(EXT_DISABLE);
        u_host_model.close_frame();
        wr(11'h006, 16'h0000, 1'b0);
        rd(11'h006, 8, 32'h5A);
        $display("test read write done");
    endtask : t_rw
    task automatic t_status;
        ext(EXT_ENABLE);
        u_host_model.close_frame();
        op(OPC_WRITE, 11'h008);
        u_host_model.tx(32'h11, 8);
        u_host_model.close_frame();
        u_host_model.open_frame();
        chk(32'(u_host_model.status()), 32'h2);
        done(1'b1);
        u_host_model.open_frame();
        chk(32'(u_host_model.status()), 32'h3);
        u_host_model.tx(32'h1, 1);
        got = 32'(u_host_model.status());
        chk(32'(got[1]), 32'h0);
        u_host_model.close_frame();
        $display("test status done");
    endtask : t_status
    task automatic t_word;
        pins(1'b1, 1'b1);
        rd(11'h003, 16, 32'hC35A);
        wr(11'h004, 16'h1234, 1'b1);
        pins(1'b0, 1'b1);
        rd(11'h008, 16, 32'h3412);
        $display("test word done");
    endtask : t_word
    task automatic t_all;
        ext(EXT_WRITE_ALL);
        u_host_model.tx(32'hA5, 8);
        done(1'b1);
        rd(11'h7FF, 8, 32'hA5);
        op(OPC_ERASE, 11'h005);
        done(1'b1);
        u_host_model.open_frame();
        u_host_model.tx(32'h0, 6);
        rd(11'h004, 16, 32'hA5FF);
        ext(EXT_ERASE_ALL);
        done(1'b1);
        rd(11'h000, 8, 32'hFF);
        pins(1'b0, 1'b0);
        wr(11'h009, 16'h0000, 1'b0);
        rd(11'h009, 8, 32'hFF);
        $display("test array done");
    endtask : t_all

    //////////////////////////////////////////////////////////////////////////
    // Clock, timeout and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        reset_n              = 1'b0;
        word_size_select_pin = 1'b0;
        program_permit_pin   = 1'b1;
        miscompares          = 0;
        samples_checked      = 0;
        cycles               = 0;
        u_host_model.tx(32'h0, 1);
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        u_host_model.tx(32'h0, 2);
        t_guard();
        t_rw();
        t_status();
        t_word();
        t_all();
        stop_test();
    end
endmodule : tb_three_wire_eeprom_command_logic
